//--- design/ddc_nco_mixer_regs.vh
// Purpose: Register indices, field positions and reset values of the tuning stage.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef DDC_NCO_MIXER_REGS_VH
`define DDC_NCO_MIXER_REGS_VH

// ==========================================================================
// Register indices
`define DDC_IDX_FSTEP_B0   14'h0314
`define DDC_IDX_FSTEP_B1   14'h0315
`define DDC_IDX_FSTEP_B2   14'h0316
`define DDC_IDX_FSTEP_B3   14'h0317
`define DDC_IDX_FSTEP_B4   14'h0318
`define DDC_IDX_FSTEP_B5   14'h031A
`define DDC_IDX_PSHIFT_B0  14'h031D
`define DDC_IDX_PSHIFT_B1  14'h031E
`define DDC_IDX_PSHIFT_B2  14'h031F
`define DDC_IDX_PSHIFT_B3  14'h0320
`define DDC_IDX_PSHIFT_B4  14'h0321
`define DDC_IDX_PSHIFT_B5  14'h0322
`define DDC_IDX_PAT_CTL    14'h0327
`define DDC_IDX_MIX_CTL    14'h0330
`define DDC_IDX_STATUS     14'h0340

// ==========================================================================
// Field positions
`define DDC_PAT_Q_BIT      2
`define DDC_PAT_I_BIT      0
`define DDC_MIX_SEL_BIT    7
`define DDC_GAIN_BIT       6
`define DDC_IFM_HI         5
`define DDC_IFM_LO         4
`define DDC_C2R_BIT        3

// ==========================================================================
// IF mode codes
`define DDC_IFM_VAR        2'h0
`define DDC_IFM_ZERO       2'h1
`define DDC_IFM_FS4        2'h2
`define DDC_IFM_TEST       2'h3

// ==========================================================================
// Reset values and pattern write mask
`define DDC_RST_STEP       48'h000000000000
`define DDC_RST_BYTE       8'h00
`define DDC_PAT_MASK       8'h05

`endif

//--- design/ddc_fifo.v
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   DEPTH must be a power of two.
`timescale 1ns/1ps

module ddc_fifo #(
    parameter WIDTH = 33,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_r;
    reg [AW:0]      rd_r;
    wire            push;
    wire            pop;

    assign level     = wr_r - rd_r;
    assign in_ready  = (level != DEPTH[AW:0]) || (DEPTH > (1 << AW));
    assign out_valid = (wr_r != rd_r);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_r[AW-1:0]];

    always @(posedge ref_clk)
    begin
        if (push)
            mem[wr_r[AW-1:0]] <= in_data;
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end

endmodule

//--- design/ddc_nco_mixer.v
// Purpose: Oscillator, mixer, gain, IF mode, complex-to-real and test patterns.
// Assumes: ADC samples arrive on ref_clk, which is the sample clock.
// Notes:   APB slave with zero wait states; output passes an 8-word FIFO.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ddc_nco_mixer_regs.vh"

module ddc_nco_mixer #(
    parameter DW         = 16,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire          ref_clk,
    input  wire          rst_b,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [15:0]   paddr,
    input  wire [31:0]   pwdata,
    input  wire [3:0]    pstrb,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          adc_valid,
    output wire          adc_ready,
    input  wire [DW-1:0] adc_i,
    input  wire [DW-1:0] adc_q,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [DW-1:0] out_i,
    output wire [DW-1:0] out_q,
    output wire          out_q_valid
);

    // ======================================================================
    // Register file
    reg  [47:0]  freq_step_r;
    reg  [47:0]  phase_shift_r;
    reg  [7:0]   pat_ctl_r;
    reg  [7:0]   mix_ctl_r;
    reg          err_r;
    wire [13:0]  idx;
    wire         setup;
    wire         wr_en;
    wire [7:0]   wb;
    wire [FIFO_AW:0] fifo_level;
    wire         fifo_in_ready;
    reg  [7:0]   rd_byte;
    reg          hit;

    assign idx     = paddr[15:2];
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite && pstrb[0] && hit;
    assign wb      = pwdata[7:0];
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_r;

    always @*
    begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            `DDC_IDX_FSTEP_B0:  rd_byte = freq_step_r[7:0];
            `DDC_IDX_FSTEP_B1:  rd_byte = freq_step_r[15:8];
            `DDC_IDX_FSTEP_B2:  rd_byte = freq_step_r[23:16];
            `DDC_IDX_FSTEP_B3:  rd_byte = freq_step_r[31:24];
            `DDC_IDX_FSTEP_B4:  rd_byte = freq_step_r[39:32];
            `DDC_IDX_FSTEP_B5:  rd_byte = freq_step_r[47:40];
            `DDC_IDX_PSHIFT_B0: rd_byte = phase_shift_r[7:0];
            `DDC_IDX_PSHIFT_B1: rd_byte = phase_shift_r[15:8];
            `DDC_IDX_PSHIFT_B2: rd_byte = phase_shift_r[23:16];
            `DDC_IDX_PSHIFT_B3: rd_byte = phase_shift_r[31:24];
            `DDC_IDX_PSHIFT_B4: rd_byte = phase_shift_r[39:32];
            `DDC_IDX_PSHIFT_B5: rd_byte = phase_shift_r[47:40];
            `DDC_IDX_PAT_CTL:   rd_byte = pat_ctl_r;
            `DDC_IDX_MIX_CTL:   rd_byte = mix_ctl_r;
            `DDC_IDX_STATUS:    rd_byte = {3'h0, !fifo_in_ready, fifo_level};
            default:            hit = 1'b0;
        endcase
    end

    // Read data and the error flag are caught in the setup cycle so that
    // the access cycle completes with no wait state.
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h00000000;
            err_r  <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= {24'h000000, rd_byte};
            err_r  <= !hit || (pwrite && (idx == `DDC_IDX_STATUS));
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            freq_step_r   <= `DDC_RST_STEP;
            phase_shift_r <= `DDC_RST_STEP;
            pat_ctl_r     <= `DDC_RST_BYTE;
            mix_ctl_r     <= `DDC_RST_BYTE;
        end
        else if (wr_en)
        begin
            case (idx)
                `DDC_IDX_FSTEP_B0:  freq_step_r[7:0]     <= wb;
                `DDC_IDX_FSTEP_B1:  freq_step_r[15:8]    <= wb;
                `DDC_IDX_FSTEP_B2:  freq_step_r[23:16]   <= wb;
                `DDC_IDX_FSTEP_B3:  freq_step_r[31:24]   <= wb;
                `DDC_IDX_FSTEP_B4:  freq_step_r[39:32]   <= wb;
                `DDC_IDX_FSTEP_B5:  freq_step_r[47:40]   <= wb;
                `DDC_IDX_PSHIFT_B0: phase_shift_r[7:0]   <= wb;
                `DDC_IDX_PSHIFT_B1: phase_shift_r[15:8]  <= wb;
                `DDC_IDX_PSHIFT_B2: phase_shift_r[23:16] <= wb;
                `DDC_IDX_PSHIFT_B3: phase_shift_r[31:24] <= wb;
                `DDC_IDX_PSHIFT_B4: phase_shift_r[39:32] <= wb;
                `DDC_IDX_PSHIFT_B5: phase_shift_r[47:40] <= wb;
                `DDC_IDX_PAT_CTL:   pat_ctl_r <= wb & `DDC_PAT_MASK;
                `DDC_IDX_MIX_CTL:   mix_ctl_r <= wb;
                default:            mix_ctl_r <= mix_ctl_r;
            endcase
        end
    end

    // ======================================================================
    // Sine lookup and saturation
    function signed [15:0] sin_lut;
        input [5:0] p;
        reg   [4:0] k;
        reg   [15:0] m;
        begin
            k = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
            case (k)
                5'h00:   m = 16'h0000;
                5'h01:   m = 16'h0C8C;
                5'h02:   m = 16'h18F9;
                5'h03:   m = 16'h2528;
                5'h04:   m = 16'h30FB;
                5'h05:   m = 16'h3C56;
                5'h06:   m = 16'h471C;
                5'h07:   m = 16'h5133;
                5'h08:   m = 16'h5A82;
                5'h09:   m = 16'h62F1;
                5'h0A:   m = 16'h6A6D;
                5'h0B:   m = 16'h70E2;
                5'h0C:   m = 16'h7641;
                5'h0D:   m = 16'h7A7C;
                5'h0E:   m = 16'h7D89;
                5'h0F:   m = 16'h7F61;
                default: m = 16'h7FFF;
            endcase
            sin_lut = p[5] ? -m : m;
        end
    endfunction

    function signed [15:0] sat16;
        input signed [34:0] v;
        begin
            if (v > 35'sh0000_07FFF)
                sat16 = 16'h7FFF;
            else if (v < -35'sh0000_08000)
                sat16 = 16'h8000;
            else
                sat16 = v[15:0];
        end
    endfunction

    // ======================================================================
    // Oscillator
    reg  [47:0]  acc_r;
    reg  [1:0]   qcnt_r;
    reg  [15:0]  ramp_r;
    wire [47:0]  phase;
    wire [1:0]   ifm;
    reg  [5:0]   lut_ph;
    wire         take;
    wire         st_ready;

    assign take      = adc_valid && st_ready;
    assign adc_ready = st_ready;
    assign phase     = acc_r + phase_shift_r;
    assign ifm       = mix_ctl_r[`DDC_IFM_HI:`DDC_IFM_LO];

    // The frequency step wraps the 48-bit accumulator once per 2^48 / step
    // samples, which places the tone at step * fs / 2^48.
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_r  <= `DDC_RST_STEP;
            qcnt_r <= 2'h0;
            ramp_r <= 16'h0000;
        end
        else if (take)
        begin
            acc_r  <= acc_r + freq_step_r;
            qcnt_r <= qcnt_r + 2'h1;
            ramp_r <= ramp_r + 16'h0001;
        end
    end

    always @*
    begin
        case (ifm)
            `DDC_IFM_VAR:  lut_ph = phase[47:42];
            `DDC_IFM_ZERO: lut_ph = 6'h00;
            `DDC_IFM_FS4:  lut_ph = {qcnt_r, 4'h0};
            default:       lut_ph = phase[47:42];
        endcase
    end

    // ======================================================================
    // Mixer and gain
    wire signed [15:0] nco_cos;
    wire signed [15:0] nco_sin;
    reg  signed [15:0] xi;
    reg  signed [15:0] xq;
    wire signed [34:0] mi;
    wire signed [34:0] mq;
    wire signed [34:0] si;
    wire signed [34:0] sq;
    wire signed [15:0] yi;
    wire signed [15:0] yq;
    wire               cplx;
    wire               gain;

    assign nco_cos = sin_lut(lut_ph + 6'h10);
    assign nco_sin = sin_lut(lut_ph);
    assign cplx    = mix_ctl_r[`DDC_MIX_SEL_BIT];
    assign gain    = mix_ctl_r[`DDC_GAIN_BIT];

    // Test IF mode feeds a full-scale constant, so the output is the
    // oscillator itself; this checks the tone without an ADC.
    always @*
    begin
        if (ifm == `DDC_IFM_TEST)
        begin
            xi = 16'sh7FFF;
            xq = 16'sh0000;
        end
        else if (cplx)
        begin
            xi = adc_i;
            xq = adc_q;
        end
        else
        begin
            xi = adc_i;
            xq = 16'sh0000;
        end
    end

    // (xi + j xq) * (cos - j sin); a real input simply has xq at zero.
    assign mi = xi * nco_cos + xq * nco_sin;
    assign mq = xq * nco_cos - xi * nco_sin;
    assign si = gain ? (mi >>> 14) : (mi >>> 15);
    assign sq = gain ? (mq >>> 14) : (mq >>> 15);
    assign yi = sat16(si);
    assign yq = sat16(sq);

    // ======================================================================
    // Complex to real and test patterns
    reg  signed [15:0] ri;
    reg  signed [15:0] ri_neg;
    wire               c2r;
    wire [15:0]        oi;
    wire [15:0]        oq;

    assign c2r = mix_ctl_r[`DDC_C2R_BIT];

    // Negation saturates so that the most negative code does not wrap.
    always @*
    begin
        ri = 16'sh0000;
        case (qcnt_r)
            2'h0:    ri = yi;
            2'h1:    ri = (yq == 16'sh8000) ? 16'sh7FFF : -yq;
            2'h2:    ri = (yi == 16'sh8000) ? 16'sh7FFF : -yi;
            default: ri = yq;
        endcase
        ri_neg = ri;
    end

    assign oi = pat_ctl_r[`DDC_PAT_I_BIT] ? ramp_r : (c2r ? ri_neg : yi);
    assign oq = pat_ctl_r[`DDC_PAT_Q_BIT] ? ~ramp_r : (c2r ? 16'h0000 : yq);

    // ======================================================================
    // Output stage and FIFO
    reg  [32:0] st_data_r;
    reg         st_vld_r;

    // The stage holds its word until the FIFO takes it; a full FIFO stops
    // the accumulator, so no sample or phase step is ever skipped.
    assign st_ready = !st_vld_r || fifo_in_ready;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_vld_r  <= 1'b0;
            st_data_r <= 33'h000000000;
        end
        else if (st_ready)
        begin
            st_vld_r <= adc_valid;
            if (adc_valid)
                st_data_r <= {oi, oq, !c2r || pat_ctl_r[`DDC_PAT_Q_BIT]};
        end
    end

    wire [32:0] fifo_out;

    ddc_fifo #(
        .WIDTH (33),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (st_vld_r),
        .in_ready  (fifo_in_ready),
        .in_data   (st_data_r),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    assign out_i       = fifo_out[32:17];
    assign out_q       = fifo_out[16:1];
    assign out_q_valid = fifo_out[0] && out_valid;

endmodule

//--- verif/ddc_adc_src.sv
// Purpose: Behavioural source of ADC sample pairs for the tuning stage.
// Assumes: One pair is handed over per valid and ready edge on ref_clk.
// Notes:   Released lanes flip, so a stale pair never passes for a live one.
`timescale 1ns/1ps

// ==========================================================================
// Sample source
module ddc_adc_src (
    input  wire        ref_clk,
    input  wire        same_ch,
    input  wire        adc_ready,
    output reg         adc_valid,
    output reg  [15:0] adc_i,
    output reg  [15:0] adc_q
);
    initial
    begin
        adc_valid = 1'b0;
        adc_i     = 16'h0000;
        adc_q     = 16'hFFFF;
    end

    // Real mixing takes one converter, so both lanes then carry the same channel.
    task send(input [15:0] si, input [15:0] sq);
    begin
        @(posedge ref_clk);
        adc_valid <= 1'b1;
        adc_i     <= si;
        adc_q     <= same_ch ? si : sq;
        do @(negedge ref_clk); while (adc_ready !== 1'b1);
        @(posedge ref_clk);
        adc_valid <= 1'b0;
        adc_i     <= ~si;
        adc_q     <= ~adc_q;
    end
    endtask
endmodule

//--- verif/ddc_nco_mixer_chk.sv
// Purpose: Port-level assertions for the tuning stage.
// Assumes: Control bytes change only while the output FIFO is empty.
// Notes:   Control shadows are rebuilt from completed APB writes.
`timescale 1ns/1ps

// ==========================================================================
// Checker
module ddc_nco_mixer_chk #(
    parameter DW = 16
) (
    input wire          ref_clk,
    input wire          rst_b,
    input wire          psel,
    input wire          penable,
    input wire          pwrite,
    input wire [15:0]   paddr,
    input wire [31:0]   pwdata,
    input wire [3:0]    pstrb,
    input wire [31:0]   prdata,
    input wire          pslverr,
    input wire          out_valid,
    input wire          out_ready,
    input wire [DW-1:0] out_i,
    input wire [DW-1:0] out_q,
    input wire          out_q_valid
);
    reg  [7:0]  pat_r;
    reg  [7:0]  ctl_r;
    reg  [13:0] wa_r;
    reg  [7:0]  wd_r;
    wire [13:0] idx = paddr[15:2];
    wire        wr  = psel && penable && pwrite && pstrb[0] && !pslverr;
    wire        zq  = ctl_r[7:3] == 5'h02 && !pat_r[2];

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pat_r <= 8'h00;
            ctl_r <= 8'h00;
            wa_r  <= 14'h0000;
            wd_r  <= 8'h00;
        end
        else if (wr)
        begin
            wa_r  <= idx;
            wd_r  <= pwdata[7:0];
            pat_r <= (idx == 14'h327) ? pwdata[7:0] : pat_r;
            ctl_r <= (idx == 14'h330) ? pwdata[7:0] : ctl_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_s;
        psel && penable && !pwrite && !pslverr;
    endsequence
    sequence pop_s;
        out_valid && out_ready;
    endsequence

    rd_back_a: assert property ((rd_s ##0 idx == wa_r && idx != 14'h327) |->
        prdata == {24'h000000, wd_r}) else $error("Read-back differs from write.");
    pat_rd_a: assert property ((rd_s ##0 idx == 14'h327) |->
        prdata == {24'h000000, pat_r & 8'h05}) else $error("Pattern byte wrong.");
    q_pat_a: assert property (out_valid && pat_r[2] |-> out_q_valid)
        else $error("Q pattern not flagged valid.");
    q_ramp_a: assert property (pop_s ##1 out_valid && pat_r[2] |->
        out_q == $past(out_q) - 16'h0001) else $error("Q pattern step wrong.");
    i_ramp_a: assert property (pop_s ##1 out_valid && pat_r[0] |->
        out_i == $past(out_i) + 16'h0001) else $error("I pattern step wrong.");
    c2r_q_a: assert property (out_valid && ctl_r[3] && !pat_r[2] |->
        !out_q_valid && out_q == 16'h0000) else $error("Q live in real output.");
    cplx_qv_a: assert property (out_valid && !ctl_r[3] |-> out_q_valid)
        else $error("Q not valid in complex output.");
    real_q_a: assert property (out_valid && zq |-> out_q == 16'h0000)
        else $error("Real zero IF gave nonzero Q.");
endmodule

bind ddc_nco_mixer ddc_nco_mixer_chk #(.DW(DW)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i), .out_q(out_q),
    .out_q_valid(out_q_valid));

//--- verif/tb.sv
// Purpose: Self-checking bench for the tuning stage.
// Assumes: The sine table reads exactly zero at a half turn.
// Notes:   Row k of the table is sample k after reset, since ramps count samples.
`timescale 1ns/1ps

// ==========================================================================
// Bench
module tb;
    localparam [879:0] TBL = {
        80'h9804_4000_2000_C001_FFF5, 80'h1005_4000_0000_0009_FFF6,
        80'h1001_4000_0000_0008_0000, 80'h9800_4000_2000_1FFF_0000,
        80'h9800_4000_2000_C001_0000, 80'hA000_4000_2000_1FFF_C000,
        80'h0000_2000_0000_1FFF_0000, 80'h3000_1111_2222_7FFE_0000,
        80'hD000_6000_9000_7FFF_8000, 80'h9000_4000_C000_3FFF_C000,
        80'h1000_4000_1234_3FFF_0000};
    localparam [10:0]  QV = 11'h73F;
    localparam [127:0] STEPX = 128'h3FFF0000_0000C000_C0000000_00003FFF;
    localparam [195:0] RI = {14'h330, 14'h327, 14'h322, 14'h321, 14'h320, 14'h31F,
        14'h31E, 14'h31D, 14'h31A, 14'h318, 14'h317, 14'h316, 14'h315, 14'h314};
    reg         ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    reg         pwrite = 1'b0, out_ready = 1'b0, same_ch = 1'b1, er;
    reg  [15:0] paddr = 16'h0000, v;
    reg  [31:0] pwdata = 32'h00000000, rd;
    reg  [79:0] r;
    reg  [13:0] a;
    reg  [7:0]  d;
    wire [31:0] prdata;
    wire [15:0] adc_i, adc_q, out_i, out_q;
    wire        pready, pslverr, adc_valid, adc_ready, out_valid, out_q_valid;
    integer     num_errors = 0, tests_run = 0, k;

    ddc_nco_mixer i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_i(adc_i),
        .adc_q(adc_q), .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i),
        .out_q(out_q), .out_q_valid(out_q_valid));
    ddc_adc_src i_src (
        .ref_clk(ref_clk), .same_ch(same_ch), .adc_ready(adc_ready),
        .adc_valid(adc_valid), .adc_i(adc_i), .adc_q(adc_q));

    always #4 ref_clk = ~ref_clk;

    task chk(input [79:0] nm, input [15:0] e, input [15:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task apb(input w, input [13:0] ad, input [7:0] wd);
    begin
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {ad, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(negedge ref_clk); while (pready !== 1'b1);
        @(posedge ref_clk);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    // The consumer stalls until it has compared the head word, then pops it.
    task pop(input [15:0] ei, input [15:0] eq, input qv);
    begin
        do @(negedge ref_clk); while (out_valid !== 1'b1);
        chk("out_i", ei, out_i);
        chk("out_q", eq, out_q);
        chk("q_valid", {15'h0000, qv}, {15'h0000, out_q_valid});
        @(posedge ref_clk);
        out_ready <= 1'b1;
        @(posedge ref_clk);
        out_ready <= 1'b0;
    end
    endtask

    task end_sim;
    begin
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (k = 0; k < 11; k = k + 1)
        begin
            r = TBL[k*80 +: 80];
            same_ch <= ~r[79];
            apb(1'b1, 14'h330, r[79:72]);
            apb(1'b1, 14'h327, r[71:64]);
            i_src.send(r[63:48], r[47:32]);
            pop(r[31:16], r[15:0], QV[k]);
        end
        same_ch <= 1'b1;
        apb(1'b1, 14'h330, 8'h00);
        apb(1'b1, 14'h327, 8'h00);
        apb(1'b1, 14'h31A, 8'h40);
        for (k = 0; k < 4; k = k + 1)
        begin
            i_src.send(16'h4000, 16'h0000);
            pop(STEPX[127-32*k -: 16], STEPX[111-32*k -: 16], 1'b1);
        end
        apb(1'b1, 14'h31A, 8'h00);
        apb(1'b1, 14'h322, 8'h40);
        i_src.send(16'h4000, 16'h0000);
        pop(16'h0000, 16'hC000, 1'b1);
        for (k = 0; k < 14; k = k + 1)
        begin
            a = RI[k*14 +: 14];
            d = 8'hA5 ^ k[7:0];
            apb(1'b1, a, d);
            apb(1'b0, a, 8'h00);
            chk("reg", {8'h00, (a == 14'h327) ? (d & 8'h05) : d}, rd[15:0]);
        end
        apb(1'b0, 14'h319, 8'h00);
        chk("unmapped", 16'h0001, {15'h0000, er});
        // Sixteen samples have been taken, so the ramps resume at 0x10.
        same_ch <= 1'b0;
        apb(1'b1, 14'h327, 8'h05);
        for (k = 0; k < 9; k = k + 1)
            i_src.send(16'h0000, 16'h0000);
        repeat (2) @(negedge ref_clk);
        chk("adc_ready", 16'h0000, {15'h0000, adc_ready});
        apb(1'b0, 14'h340, 8'h00);
        chk("status", 16'h0018, rd[15:0]);
        apb(1'b1, 14'h340, 8'hFF);
        chk("st_write", 16'h0001, {15'h0000, er});
        for (k = 0; k < 9; k = k + 1)
        begin
            v = 16'h0010 + k[15:0];
            pop(v, ~v, 1'b1);
        end
        @(negedge ref_clk);
        chk("out_valid", 16'h0000, {15'h0000, out_valid});
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (k = 0; k < 14; k = k + 1)
        begin
            apb(1'b0, RI[k*14 +: 14], 8'h00);
            chk("reset", 16'h0000, rd[15:0]);
        end
        end_sim;
    end

    // The sequence needs a few hundred cycles; this margin is over sixty times that.
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        end_sim;
    end
endmodule
